// File: design/dmau_defines.svh
// constants of the data-memory address unit: data space, internal
// register map, axi4-lite offsets and field positions
`ifndef DMAU_DEFINES_SVH
`define DMAU_DEFINES_SVH
// data space
`define DMAU_ADDR_W        12
`define DMAU_LOW_LIMIT     8'h60
`define DMAU_SFR_BANK      4'hf
`define DMAU_IMPL_BANKS    5'h08
`define DMAU_BSR_MASK      8'h0f
// internal register addresses inside the special function bank
`define DMAU_PORT_GRP      7'h7f
`define DMAU_STATUS_ADDR   12'hfd8
`define DMAU_BSR_ADDR      12'hfd9
// sub-addresses inside one pointer group of eight
`define DMAU_SUB_PLAIN     3'h0
`define DMAU_SUB_POST_DECREMENT_PORT   3'h1
`define DMAU_SUB_POST_INCREMENT_PORT   3'h2
`define DMAU_SUB_PRE_INCREMENT_PORT    3'h3
`define DMAU_SUB_INDEXED   3'h4
`define DMAU_SUB_LOW       3'h5
`define DMAU_SUB_HIGH      3'h6
// status flag positions
`define DMAU_FLAG_C        0
`define DMAU_FLAG_DC       1
`define DMAU_FLAG_Z        2
`define DMAU_FLAG_OV       3
`define DMAU_FLAG_N        4
// axi4-lite byte offsets
`define DMAU_OFS_BANK      8'h00
`define DMAU_OFS_PTR0      8'h04
`define DMAU_OFS_PTR1      8'h08
`define DMAU_OFS_PTR2      8'h0c
`define DMAU_OFS_STATUS    8'h10
`define DMAU_RESP_OKAY     2'h0
`define DMAU_RESP_SLVERR   2'h2
`endif

// File: design/dmau_pkg.sv
// types shared by the data-memory address unit
// assumes dmau_defines.svh is compiled alongside
package dmau_pkg;
  // request kinds from instruction execution
  typedef enum logic [2:0] {
    DMAU_KIND_DIRECT = 3'h1,
    DMAU_KIND_FULL   = 3'h2,
    DMAU_KIND_BANKLD = 3'h4
  } dmau_kind_e;
  // where a read answer is taken from
  typedef enum logic [1:0] {
    DMAU_SRC_RAM  = 2'h1,
    DMAU_SRC_HELD = 2'h2
  } dmau_src_e;
endpackage : dmau_pkg

// File: design/dmau_core.sv
// data-memory address unit: direct, access-bank and indirect address
// forming, pointer auto-modify, guarded status writes, axi4-lite view
// assumes a ram with combinational read on ram_addr and the core on
// sys_clk issuing at most one request per cycle
//
// Functional notes
// - access bank is low 96 bytes of bank 0 plus top 160 of bank 15
// - access bit 0 uses access bank, contiguous; otherwise bank select bank
// - bank select low nibble gives address top; upper nibble reads zero
// - unimplemented bank reads zero, drops writes; flags still update
// - data memory is sixteen banks of 256 bytes each
// - file-to-file move uses full 12-bit addresses, ignores bank select
// - three 12-bit pointers, each held as high and low bytes
// - indirect data port accesses location held in its pointer
// - pointer at a port: read gives 00h sets zero; write stores nothing, but a stepping port still moves the pointer
// - five ports per pointer: plain, post_decrement_port, post_increment_port, pre_increment_port, indexed
// - indexed adds signed working register; nothing modified
// - pointer auto-modify never changes status flags
// - increment and decrement carry across all twelve bits
// - data write to own pointer byte beats its auto-modify
// - status as destination: alu flags win over the written value
// - carry and digit carry are borrows in subtraction
// - bank load literal writes bank select directly
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "dmau_defines.svh"
module dmau_core (
  input  wire logic        sys_clk,        // core clock
  input  wire logic        rst_n,          // sync reset, active low
  input  wire logic        req_valid,      // one access this cycle
  input  wire logic [2:0]  req_kind,       // dmau_kind_e code
  input  wire logic        req_write,      // write, else read
  input  wire logic        req_access_sel, // instruction access bit
  input  wire logic [7:0]  req_file,       // 8-bit file operand
  input  wire logic [11:0] req_full,       // 12-bit move operand
  input  wire logic [7:0]  req_wdata,      // write data or literal
  input  wire logic [7:0]  working_register, // index for indexed mode
  input  wire logic [4:0]  req_flag_mask,  // flags the alu sets
  input  wire logic [4:0]  req_flag_val,   // alu flag values
  output logic      [11:0] ram_addr,       // ram address
  output logic             ram_re,         // ram read strobe
  output logic             ram_we,         // ram write strobe
  output logic      [7:0]  ram_wdata,      // ram write data
  input  wire logic [7:0]  ram_rdata,      // ram read data
  output logic             rsp_valid,      // read answer pulse
  output logic      [7:0]  rsp_rdata,      // read answer data
  output logic      [7:0]  status_out,     // status register
  input  wire logic        s_axi_awvalid,  // axi write address valid
  output logic             s_axi_awready,  // axi write address ready
  input  wire logic [7:0]  s_axi_awaddr,   // axi write address
  input  wire logic        s_axi_wvalid,   // axi write data valid
  output logic             s_axi_wready,   // axi write data ready
  input  wire logic [31:0] s_axi_wdata,    // axi write data
  input  wire logic [3:0]  s_axi_wstrb,    // axi byte strobes
  output logic             s_axi_bvalid,   // axi write response valid
  input  wire logic        s_axi_bready,   // axi write response ready
  output logic      [1:0]  s_axi_bresp,    // axi write response
  input  wire logic        s_axi_arvalid,  // axi read address valid
  output logic             s_axi_arready,  // axi read address ready
  input  wire logic [7:0]  s_axi_araddr,   // axi read address
  output logic             s_axi_rvalid,   // axi read data valid
  input  wire logic        s_axi_rready,   // axi read data ready
  output logic      [31:0] s_axi_rdata,    // axi read data
  output logic      [1:0]  s_axi_rresp     // axi read response
);
  logic [3:0]  bsr_reg;
  logic [3:0]  bsr_next;
  logic [4:0]  status_reg;
  logic [4:0]  status_next;
  logic [11:0] ptr_reg  [3];
  logic [11:0] ptr_next [3];

  // request kind decode
  wire kind_full  = (req_kind == dmau_pkg::DMAU_KIND_FULL);
  wire kind_bank  = (req_kind == dmau_pkg::DMAU_KIND_BANKLD);
  wire req_access = req_valid & ~kind_bank;

  wire [11:0] acc_addr = (req_file < `DMAU_LOW_LIMIT) ? {4'h0, req_file}
                         : {`DMAU_SFR_BANK, req_file};
  wire [11:0] dir_addr = req_access_sel ? {bsr_reg, req_file} : acc_addr;
  wire [11:0] tgt_addr = kind_full ? req_full : dir_addr;

  // indirect port decode on the operand address
  wire        tgt_grp  = (tgt_addr[11:5] == `DMAU_PORT_GRP) &
                         (tgt_addr[4:3] != 2'h3);
  wire [2:0]  tgt_sub  = tgt_addr[2:0];
  wire [1:0]  tgt_ptr  = tgt_addr[4:3];
  wire        port_hit = req_access & tgt_grp &
                         (tgt_sub <= `DMAU_SUB_INDEXED);
  wire [11:0] ptr_cur  = ptr_reg[tgt_ptr];
  wire        mode_pre = (tgt_sub == `DMAU_SUB_PRE_INCREMENT_PORT);
  wire        mode_idx = (tgt_sub == `DMAU_SUB_INDEXED);
  wire        mode_inc = port_hit & (mode_pre |
                         (tgt_sub == `DMAU_SUB_POST_INCREMENT_PORT));
  wire        mode_dec = port_hit & (tgt_sub == `DMAU_SUB_POST_DECREMENT_PORT);
  wire [11:0] idx_ofs  = {{4{working_register[7]}}, working_register};
  wire [11:0] ind_addr = mode_pre ? ptr_cur + 12'h001
                         : mode_idx ? ptr_cur + idx_ofs : ptr_cur;
  // port access lands on the pointed location
  wire [11:0] eff_addr = port_hit ? ind_addr : tgt_addr;

  // effective address decode
  wire        eff_grp  = (eff_addr[11:5] == `DMAU_PORT_GRP) &
                         (eff_addr[4:3] != 2'h3);
  wire        ind_self = port_hit & eff_grp &
                         (eff_addr[2:0] <= `DMAU_SUB_INDEXED);
  wire        hit_low  = eff_grp & (eff_addr[2:0] == `DMAU_SUB_LOW);
  wire        hit_high = eff_grp & (eff_addr[2:0] == `DMAU_SUB_HIGH);
  wire [1:0]  eff_ptr  = eff_addr[4:3];
  wire        hit_stat = (eff_addr == `DMAU_STATUS_ADDR);
  wire        hit_bsr  = (eff_addr == `DMAU_BSR_ADDR);
  wire        hit_int  = hit_low | hit_high | hit_stat | hit_bsr;
  // sixteen banks, only the first few populated plus the sfr bank
  wire        unimpl   = ({1'b0, eff_addr[11:8]} >= `DMAU_IMPL_BANKS) &
                         (eff_addr[11:8] != `DMAU_SFR_BANK);

  // write qualifiers; drop writes to missing banks
  wire        wr_ok    = req_access & req_write & ~ind_self & ~unimpl;
  wire        wr_stat  = wr_ok & hit_stat;
  wire        wr_bsr   = wr_ok & hit_bsr;
  wire        wr_ram   = wr_ok & ~hit_int & ~eff_grp;
  wire        rd_ram   = req_access & ~req_write & ~ind_self & ~unimpl &
                         ~hit_int & ~eff_grp;

  // internal read mux; upper bank select nibble reads zero
  wire [11:0] eff_pval = ptr_reg[eff_ptr];
  wire [7:0]  int_rd   = hit_stat ? {3'h0, status_reg}
                         : hit_bsr ? {4'h0, bsr_reg}
                         : hit_low ? eff_pval[7:0]
                         : hit_high ? {4'h0, eff_pval[11:8]} : 8'h00;
  // self-pointing read and missing bank give zero
  wire [7:0]  held_rd  = (ind_self | unimpl) ? 8'h00 : int_rd;

  // bank select next value, core wins over the bus
  wire        axi_wr;
  wire [7:0]  axi_wofs;
  // held bus data: the master may move wdata once it is taken
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  assign bsr_next = kind_bank & req_valid ? req_wdata[3:0]
                    : wr_bsr ? req_wdata[3:0]
                    : axi_wr & (axi_wofs == `DMAU_OFS_BANK) &
                      w_strb_reg[0] ? w_data_reg[3:0] : bsr_reg;

  // status next value
  // pointer motion is not a flag source
  wire        flag_en  = req_access & ~(ind_self & req_write);
  wire        zero_frc = req_access & ind_self & ~req_write;
  // any alu flag locks all five against the data write
  wire        alu_flags = (req_flag_mask != 5'h00);
  logic [4:0] stat_base;
  always_comb begin
    stat_base = status_reg;
    if (axi_wr & (axi_wofs == `DMAU_OFS_STATUS) & w_strb_reg[0]) begin
      stat_base = w_data_reg[4:0];
    end
    if (wr_stat & ~alu_flags) begin
      stat_base = req_wdata[4:0];
    end
  end
  // alu flags override the written value
  // borrow polarity comes from the alu flag values
  assign status_next = zero_frc
                       ? (stat_base | (5'h01 << `DMAU_FLAG_Z))
                       : flag_en ? ((stat_base & ~req_flag_mask) |
                                    (req_flag_val & req_flag_mask))
                       : stat_base;

  // pointer next values, one per pointer
  // three twelve-bit pointers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      wire own   = (tgt_ptr == 2'(gi));
      wire wlow  = wr_ok & hit_low & (eff_ptr == 2'(gi));
      wire whigh = wr_ok & hit_high & (eff_ptr == 2'(gi));
      wire aw    = axi_wr & (axi_wofs == 8'(4 * gi + 4));
      always_comb begin
        ptr_next[gi] = ptr_reg[gi];
        if (aw & w_strb_reg[0]) begin
          ptr_next[gi][7:0] = w_data_reg[7:0];
        end
        if (aw & w_strb_reg[1]) begin
          ptr_next[gi][11:8] = w_data_reg[11:8];
        end
        // full-width step, skipped when its own byte is written
        if (own & mode_inc & ~(wlow | whigh)) begin
          ptr_next[gi] = ptr_reg[gi] + 12'h001;
        end
        if (own & mode_dec & ~(wlow | whigh)) begin
          ptr_next[gi] = ptr_reg[gi] - 12'h001;
        end
        if (wlow) begin
          ptr_next[gi][7:0] = req_wdata;
        end
        if (whigh) begin
          ptr_next[gi][11:8] = req_wdata[3:0];
        end
      end
    end
  endgenerate

  // architectural state
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bsr_reg    <= 4'h0;
      status_reg <= 5'h00;
      ptr_reg    <= '{12'h000, 12'h000, 12'h000};
    end else begin
      bsr_reg    <= bsr_next;
      status_reg <= status_next;
      ptr_reg    <= ptr_next;
    end
  end

  // stage one: ram strobes from flops; held data waits a cycle
  logic [1:0] src_reg;
  logic [7:0] held_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ram_addr  <= 12'h000;
      ram_re    <= 1'b0;
      ram_we    <= 1'b0;
      ram_wdata <= 8'h00;
      src_reg   <= 2'h0;
      held_reg  <= 8'h00;
    end else begin
      ram_addr  <= eff_addr;
      ram_re    <= rd_ram;
      ram_we    <= wr_ram;
      ram_wdata <= req_wdata;
      src_reg   <= ~req_access | req_write ? 2'h0
                   : rd_ram ? dmau_pkg::DMAU_SRC_RAM
                   : dmau_pkg::DMAU_SRC_HELD;
      held_reg  <= held_rd;
    end
  end

  // stage two: read answer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= (src_reg != 2'h0);
      rsp_rdata <= (src_reg == dmau_pkg::DMAU_SRC_RAM) ? ram_rdata
                   : held_reg;
    end
  end
  assign status_out = {3'h0, status_reg};

  // axi4-lite slave: address and data held until both present
  logic       aw_full_reg;
  logic       w_full_reg;
  logic [7:0] aw_addr_reg;
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign axi_wr   = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign axi_wofs = aw_addr_reg;
  wire   w_known  = (aw_addr_reg <= `DMAU_OFS_STATUS) &
                    (aw_addr_reg[1:0] == 2'h0);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DMAU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (axi_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_known ? `DMAU_RESP_OKAY : `DMAU_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
      end
    end
  end

  // read side: one cycle from address to data
  wire [31:0] ar_data = (s_axi_araddr == `DMAU_OFS_BANK)
                        ? {28'h0, bsr_reg}
                        : (s_axi_araddr == `DMAU_OFS_PTR0)
                        ? {20'h0, ptr_reg[0]}
                        : (s_axi_araddr == `DMAU_OFS_PTR1)
                        ? {20'h0, ptr_reg[1]}
                        : (s_axi_araddr == `DMAU_OFS_PTR2)
                        ? {20'h0, ptr_reg[2]}
                        : {27'h0, status_reg};
  wire        ar_known = (s_axi_araddr <= `DMAU_OFS_STATUS) &
                         (s_axi_araddr[1:0] == 2'h0);
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DMAU_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ar_known ? ar_data : 32'h0000_0000;
      s_axi_rresp  <= ar_known ? `DMAU_RESP_OKAY : `DMAU_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks on the address paths and state updates
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_access_low: assert property (
    req_access & ~kind_full & ~req_access_sel & (req_file == 8'h5f)
    |-> (eff_addr == 12'h05f) | port_hit)
    else $error("access bank low end misplaced");
  a_access_high: assert property (
    req_access & ~kind_full & ~req_access_sel & (req_file == 8'h60)
    |-> ##1 ram_addr == 12'hf60)
    else $error("access bank high start misplaced");
  a_bank_upper: assert property (
    ##1 status_out[7:5] == 3'h0 && s_axi_rvalid && $past(s_axi_araddr)
    == `DMAU_OFS_BANK && $past(~s_axi_rvalid) |-> s_axi_rdata[31:4] == 0)
    else $error("bank select upper bits not zero");
  a_unimpl_drop: assert property (
    req_access & req_write & unimpl |-> ##1 !ram_we)
    else $error("write reached a missing bank");
  a_move_full: assert property (
    req_access & kind_full & ~req_write & ~tgt_grp
    & (req_full[11:8] < 4'h8) |-> ##1 ram_re && ram_addr == $past(req_full))
    else $error("move address not taken whole");
  a_self_read: assert property (
    req_access & ind_self & ~req_write
    |-> ##1 status_reg[`DMAU_FLAG_Z] ##1 rsp_valid && rsp_rdata == 8'h00)
    else $error("self-pointing read not zero");
  a_post_increment_port_step: assert property (
    req_access & mode_inc & ~mode_pre & ~(wr_ok & eff_grp)
    |=> ptr_reg[$past(tgt_ptr)] == $past(ptr_cur) + 12'h001)
    else $error("post-increment step wrong");
  a_index_keep: assert property (
    req_access & port_hit & mode_idx & ~(wr_ok & eff_grp) & ~axi_wr
    |=> $stable(ptr_reg[0]) && $stable(ptr_reg[1]) && $stable(ptr_reg[2]))
    else $error("indexed access moved a pointer");
  a_status_guard: assert property (
    wr_stat & alu_flags & ~axi_wr |=> status_reg ==
    (($past(status_reg) & ~$past(req_flag_mask)) |
     ($past(req_flag_val) & $past(req_flag_mask))))
    else $error("alu flags lost to status write");
  a_bank_load: assert property (
    req_valid & kind_bank |=> bsr_reg == $past(req_wdata[3:0]))
    else $error("bank load literal missed");

  c_post_decrement_port: cover property (req_access & mode_dec ##1 ram_re);
  c_self_write: cover property (req_access & ind_self & req_write);
  c_axi_write: cover property (axi_wr ##1 s_axi_bvalid);
endmodule : dmau_core
`default_nettype wire

// File: tb/dmau_ram_model.sv
// data ram standing behind the address unit, byte wide, 4096 places
// assumes the unit drives registered strobes on sys_clk and reads
// combinationally while ram_re is high
`timescale 1ns/10ps
`default_nettype none
module dmau_ram_model (
  input  wire logic        sys_clk,   // core clock
  input  wire logic [11:0] ram_addr,  // byte address
  input  wire logic        ram_re,    // read strobe
  input  wire logic        ram_we,    // write strobe
  input  wire logic [7:0]  ram_wdata, // write data
  output logic      [7:0]  ram_rdata  // read data
);
  logic [7:0] mem [0:4095];
  logic [7:0] last_reg;

  // clean start so the self-pointing write check sees a known value
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    last_reg = 8'h00;
  end

  // store and track the last value read out
  always @(posedge sys_clk) begin
    if (ram_we) mem[ram_addr] <= ram_wdata;
    if (ram_re) last_reg <= mem[ram_addr];
  end

  // released bus shows the inverse, never a stale copy
  assign ram_rdata = ram_re ? mem[ram_addr] : ~last_reg;
endmodule : dmau_ram_model
`default_nettype wire

// File: tb/test_data_memory_address_unit.sv
// bench of the data-memory address unit: core requests and axi4-lite
// assumes dmau_core, dmau_pkg and the ram model are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "dmau_defines.svh"
module test_data_memory_address_unit;
  logic        sys_clk, rst_n, req_valid, req_write, req_access_sel;
  logic [2:0]  req_kind;
  logic [7:0]  req_file, req_wdata, working_register, ram_wdata, ram_rdata;
  logic [11:0] req_full, ram_addr;
  logic [4:0]  req_flag_mask, req_flag_val;
  logic        ram_re, ram_we, rsp_valid;
  logic [7:0]  rsp_rdata, status_out, s_axi_awaddr, s_axi_araddr, rd, o;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] ta [5], tp [5];
  int          errors, compares;

  dmau_core uut (.sys_clk, .rst_n, .req_valid, .req_kind, .req_write,
    .req_access_sel, .req_file, .req_full, .req_wdata, .working_register,
    .req_flag_mask, .req_flag_val, .ram_addr, .ram_re, .ram_we, .ram_wdata,
    .ram_rdata, .rsp_valid, .rsp_rdata, .status_out, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  dmau_ram_model ram (.sys_clk, .ram_addr, .ram_re, .ram_we, .ram_wdata,
    .ram_rdata);

  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      errors++;
    end
  endtask : chk

  // one core request; reads wait for the answer pulse under a bound
  task automatic rq(input logic [2:0] k, input logic w, input logic s,
                    input logic [7:0] f, input logic [11:0] fu,
                    input logic [7:0] d, input logic [4:0] m, input logic [4:0] v);
    int i;
    @(posedge sys_clk);
    req_valid <= 1'b1; req_kind <= k; req_write <= w; req_access_sel <= s;
    req_file <= f; req_full <= fu; req_wdata <= d;
    req_flag_mask <= m; req_flag_val <= v;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    if (w) repeat (2) @(posedge sys_clk);
    else begin
      for (i = 0; i < 6 && rsp_valid !== 1'b1; i++) @(posedge sys_clk);
      if (i == 6) begin errors++; report_and_stop(); end
      rd = rsp_rdata;
    end
  endtask : rq

  task automatic fw(input logic [11:0] a, input logic [7:0] d,
                    input logic [4:0] m, input logic [4:0] v);
    rq(dmau_pkg::DMAU_KIND_FULL, 1'b1, 1'b0, 8'h00, a, d, m, v);
  endtask : fw

  // axi write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] r);
    int i;
    @(posedge sys_clk);
    s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d; s_axi_wstrb <= s; s_axi_bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 20) begin errors++; report_and_stop(); end
    chk(32'(s_axi_bresp), 32'(r));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] r);
    int i;
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 20) begin errors++; report_and_stop(); end
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(r));
  endtask : axr

  // clock, and a watchdog that cuts a hang short
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end

  initial begin
    errors = 0; compares = 0; rst_n = 1'b0; req_valid = 1'b0;
    req_kind = 3'h0; req_write = 1'b0; req_access_sel = 1'b0;
    req_file = 8'h00; req_full = 12'h000; req_wdata = 8'h00;
    working_register = 8'h00; req_flag_mask = 5'h00; req_flag_val = 5'h00;
    s_axi_awvalid = 1'b0; s_axi_awaddr = 8'h00; s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_araddr = 8'h00; s_axi_rready = 1'b0;
    ta = '{12'h100, 12'h100, 12'h0ff, 12'h101, 12'h100};
    tp = '{12'h100, 12'h0ff, 12'h100, 12'h101, 12'h101};
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset view of every register
    for (int n = 0; n < 5; n++) axr(8'(4 * n), 32'h0, `DMAU_RESP_OKAY);
    chk(32'(status_out), 32'h0);
    axw(`DMAU_OFS_BANK, 32'hff, 4'hf, `DMAU_RESP_OKAY);
    axr(`DMAU_OFS_BANK, 32'h0f, `DMAU_RESP_OKAY);
    axw(8'h14, 32'h1, 4'hf, `DMAU_RESP_SLVERR);
    axr(8'h14, 32'h0, `DMAU_RESP_SLVERR);
    // literal bank load, then banked and access-bank direct writes
    rq(dmau_pkg::DMAU_KIND_BANKLD, 1'b1, 1'b0, 8'h0, 12'h0, 8'h02, 5'h0, 5'h0);
    axr(`DMAU_OFS_BANK, 32'h02, `DMAU_RESP_OKAY);
    rq(dmau_pkg::DMAU_KIND_DIRECT, 1'b1, 1'b1, 8'h34, 12'h0, 8'ha5, 5'h0, 5'h0);
    chk(32'(ram.mem[12'h234]), 32'ha5);
    rq(dmau_pkg::DMAU_KIND_DIRECT, 1'b0, 1'b1, 8'h34, 12'h0, 8'h0, 5'h0, 5'h0);
    chk(32'(rd), 32'ha5);
    rq(dmau_pkg::DMAU_KIND_DIRECT, 1'b1, 1'b0, 8'h5f, 12'h0, 8'h11, 5'h0, 5'h0);
    chk(32'(ram.mem[12'h05f]), 32'h11);
    rq(dmau_pkg::DMAU_KIND_DIRECT, 1'b1, 1'b0, 8'h60, 12'h0, 8'h22, 5'h0, 5'h0);
    chk(32'(ram.mem[12'hf60]), 32'h22);
    // missing bank nine: zero reads, dropped writes, live flags
    rq(dmau_pkg::DMAU_KIND_BANKLD, 1'b1, 1'b0, 8'h0, 12'h0, 8'h09, 5'h0, 5'h0);
    ram.mem[12'h910] = 8'h3c;
    rq(dmau_pkg::DMAU_KIND_DIRECT, 1'b0, 1'b1, 8'h10, 12'h0, 8'h0, 5'h04, 5'h04);
    chk(32'(rd), 32'h0);
    chk(32'(status_out), 32'h04);
    rq(dmau_pkg::DMAU_KIND_DIRECT, 1'b1, 1'b1, 8'h10, 12'h0, 8'h77, 5'h04, 5'h0);
    chk(32'(ram.mem[12'h910]), 32'h3c);
    chk(32'(status_out), 32'h0);
    fw(12'h123, 8'h5a, 5'h0, 5'h0);
    chk(32'(ram.mem[12'h123]), 32'h5a);
    rq(dmau_pkg::DMAU_KIND_FULL, 1'b0, 1'b0, 8'h0, 12'h123, 8'h0, 5'h0, 5'h0);
    chk(32'(rd), 32'h5a);
    fw(`DMAU_BSR_ADDR, 8'hf3, 5'h0, 5'h0);
    axr(`DMAU_OFS_BANK, 32'h03, `DMAU_RESP_OKAY);
    // each pointer steps across the byte boundary
    for (int n = 0; n < 3; n++) begin
      o = 8'h04 + 8'(4 * n);
      axw(o, 32'h0ff, 4'h3, `DMAU_RESP_OKAY);
      fw(12'hfe2 + 12'(8 * n), 8'h30 + 8'(n), 5'h0, 5'h0);
      chk(32'(ram.mem[12'h0ff]), 32'h30 + n);
      axr(o, 32'h100, `DMAU_RESP_OKAY);
    end
    // the five ports of pointer zero, index minus one
    working_register <= 8'hff;
    for (int i = 0; i < 5; i++) begin
      fw(12'hfe0 + 12'(i), 8'h40 + 8'(i), 5'h0, 5'h0);
      chk(32'(ram.mem[ta[i]]), 32'h40 + i);
      axr(`DMAU_OFS_PTR0, 32'(tp[i]), `DMAU_RESP_OKAY);
    end
    // wrap to zero leaves zero flag alone
    axw(`DMAU_OFS_PTR0, 32'hfff, 4'h3, `DMAU_RESP_OKAY);
    fw(12'hfe2, 8'h55, 5'h0, 5'h0);
    chk(32'(ram.mem[12'hfff]), 32'h55);
    axr(`DMAU_OFS_PTR0, 32'h0, `DMAU_RESP_OKAY);
    chk(32'(status_out), 32'h0);
    rq(dmau_pkg::DMAU_KIND_FULL, 1'b0, 1'b0, 8'h0, 12'hfe4, 8'h0, 5'h0, 5'h0);
    chk(32'(rd), 32'h55);
    // pointer aimed at its own port
    axw(`DMAU_OFS_PTR0, 32'hfe0, 4'h3, `DMAU_RESP_OKAY);
    rq(dmau_pkg::DMAU_KIND_FULL, 1'b0, 1'b0, 8'h0, 12'hfe0, 8'h0, 5'h0, 5'h0);
    chk(32'(rd), 32'h0);
    chk(32'(status_out), 32'h04);
    fw(12'hfe0, 8'h99, 5'h04, 5'h0);
    chk(32'(status_out), 32'h04);
    chk(32'(ram.mem[12'hfe0]), 32'h0);
    // data write to own low byte beats the increment
    axw(`DMAU_OFS_PTR0, 32'hfe5, 4'h3, `DMAU_RESP_OKAY);
    fw(12'hfe2, 8'h42, 5'h0, 5'h0);
    axr(`DMAU_OFS_PTR0, 32'hf42, `DMAU_RESP_OKAY);
    rq(dmau_pkg::DMAU_KIND_FULL, 1'b0, 1'b0, 8'h0, 12'hfe6, 8'h0, 5'h0, 5'h0);
    chk(32'(rd), 32'h0f);
    // flag-neutral move into status, then guarded clear
    fw(`DMAU_STATUS_ADDR, 8'h1b, 5'h0, 5'h0);
    chk(32'(status_out), 32'h1b);
    fw(`DMAU_STATUS_ADDR, 8'h00, 5'h04, 5'h04);
    chk(32'(status_out), 32'h1f);
    // borrow values from the alu land as given
    fw(12'h200, 8'h01, 5'h03, 5'h00);
    chk(32'(status_out), 32'h1c);
    report_and_stop();
  end
endmodule : test_data_memory_address_unit
`default_nettype wire
